// ==== design/ufw_pkg.sv ====
// Package of register map, field positions, reset values and codes for the UART frame block
package ufw_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_MODE      = 5'h00;
  localparam logic [4:0] OFS_CONTROL   = 5'h04;
  localparam logic [4:0] OFS_MODE_TWO  = 5'h08;
  localparam logic [4:0] OFS_DATA      = 5'h0c;
  localparam logic [4:0] OFS_BAUD      = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT  = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK  = 5'h18;
  localparam logic [4:0] OFS_STATUS    = 5'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_SEL_LO     = 0;
  localparam int MODE_SEL_HI     = 1;
  localparam int MODE_TX_NINTH   = 2;
  localparam int MODE_WAKEUP     = 3;
  localparam int MODE_RX_ENABLE  = 4;
  localparam int CTRL_PAR_EN     = 0;
  localparam int CTRL_PAR_EVEN   = 1;
  localparam int CTRL_RX_NINTH   = 2;
  localparam int CTRL_PAR_ERR    = 3;
  localparam int CTRL_FRAME_ERR  = 4;
  localparam int MODE2_STOP_LEN  = 0;
  localparam int MODE2_OPEN_DRN  = 1;
  localparam int IRQ_TX_DONE     = 0;
  localparam int IRQ_RX_DONE     = 1;
  localparam int IRQ_RX_ERROR    = 2;
  localparam int STAT_TX_BUSY    = 0;
  localparam int STAT_RX_BUSY    = 1;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [4:0]  MODE_RESET   = 5'h00;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam logic [1:0]  MODE2_RESET  = 2'h0;
  localparam logic [15:0] BAUD_RESET   = 16'h01b2;
  localparam logic [2:0]  IRQ_RESET    = 3'h0;
  localparam int          FRAME_W      = 12;
  localparam int          PAYLOAD_W    = 10;

  // ----------------------------------------------------------------
  // Mode select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_UART7 = 2'b01,
    MODE_UART8 = 2'b10,
    MODE_UART9 = 2'b11
  } ufw_mode_type;

endpackage

// ==== design/ufw_uart.sv ====
// UART channel with 7/8/9-bit frames, parity, stop length and wake-up filter
//
// Notes on behaviour
// - Mode select 01 runs 7-bit asynchronous frames.
// - In 7 and 8-bit modes a parity bit is sent only when enabled.
// - Parity is even or odd per the polarity bit, both sent and checked.
// - Stop bit count follows the stop length bit of mode register two.
// - Mode select 10 runs 8-bit asynchronous frames.
// - Mode select 11 runs 9-bit asynchronous frames.
// - In 9-bit mode the transmit ninth bit is sent as data bit 8.
// - In 9-bit mode the received bit 8 is stored in the control register.
// - A wake-up enable bit exists for 9-bit slave filtering.
// - In 9-bit mode with wake-up on, receive interrupt only for frames whose ninth bit is 1.
`timescale 1ns/1ps
module ufw_uart #(
  parameter int BAUD_W = 16
) (
  // Clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  // Register port
  input  wire logic [4:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [31:0] REG_RDATA_OUT,
  // Serial pins
  input  wire logic        SERIAL_IN_PIN_IN,
  output logic             SERIAL_OUT_PIN_OUT,
  output logic             SERIAL_OUT_OE_OUT,
  // Interrupt
  output logic             IRQ_OUT
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Data bits carried by each mode, ninth bit counted in 9-bit mode
  function automatic logic [3:0] data_bits(input logic [1:0] m);
    unique case (ufw_pkg::ufw_mode_type'(m))
      ufw_pkg::MODE_UART7: data_bits = 4'h7;
      ufw_pkg::MODE_UART8: data_bits = 4'h8;
      ufw_pkg::MODE_UART9: data_bits = 4'h9;
      ufw_pkg::MODE_OFF:   data_bits = 4'h0;
    endcase
  endfunction

  // Parity bit for the low n bits of d
  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
                                     input logic even);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        acc = acc ^ d[i];
      end
    end
    parity_of = even ? acc : ~acc;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [4:0]        mode_reg;
  logic [1:0]        ctrl_reg;
  logic [1:0]        mode2_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [2:0]        irq_stat_reg;
  logic [2:0]        irq_mask_reg;
  logic [7:0]        rx_data_reg;
  logic              rx_ninth_reg;
  logic              par_err_reg;
  logic              frame_err_reg;
  logic [31:0]       rdata_reg;

  logic [1:0] mode_sel;
  logic [3:0] nbits;
  logic       par_on;
  logic       stop_two;
  logic       wr_data;
  logic       tx_done_evt;
  logic       rx_done_evt;
  logic       rx_err_evt;

  assign mode_sel = mode_reg[ufw_pkg::MODE_SEL_HI:ufw_pkg::MODE_SEL_LO];
  assign nbits    = data_bits(mode_sel);
  // Parity only in 7/8-bit modes; 9-bit mode ignores the enable bit
  assign par_on   = ctrl_reg[ufw_pkg::CTRL_PAR_EN] &&
                    (mode_sel != ufw_pkg::MODE_UART9);
  assign stop_two = mode2_reg[ufw_pkg::MODE2_STOP_LEN];
  assign wr_data  = REG_WR_IN && (REG_ADDR_IN == ufw_pkg::OFS_DATA);

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      mode_reg     <= ufw_pkg::MODE_RESET;
      ctrl_reg     <= ufw_pkg::CTRL_RESET;
      mode2_reg    <= ufw_pkg::MODE2_RESET;
      baud_reg     <= BAUD_W'(ufw_pkg::BAUD_RESET);
      irq_mask_reg <= ufw_pkg::IRQ_RESET;
    end else if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        ufw_pkg::OFS_MODE:     mode_reg     <= REG_WDATA_IN[4:0];
        ufw_pkg::OFS_CONTROL:  ctrl_reg     <= REG_WDATA_IN[1:0];
        ufw_pkg::OFS_MODE_TWO: mode2_reg    <= REG_WDATA_IN[1:0];
        ufw_pkg::OFS_BAUD:     baud_reg     <= REG_WDATA_IN[BAUD_W-1:0];
        ufw_pkg::OFS_IRQ_MASK: irq_mask_reg <= REG_WDATA_IN[2:0];
        default:               ;
      endcase
    end
  end

  // Sticky status; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      irq_stat_reg <= ufw_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg &
                       ~((REG_WR_IN && REG_ADDR_IN == ufw_pkg::OFS_IRQ_STAT) ?
                         REG_WDATA_IN[2:0] : 3'h0)) |
                      {rx_err_evt, rx_done_evt, tx_done_evt};
    end
  end

  assign IRQ_OUT = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [ufw_pkg::FRAME_W-1:0]   tx_frame;
  logic [ufw_pkg::FRAME_W-1:0]   tx_shift_reg;
  logic [ufw_pkg::PAYLOAD_W-1:0] tx_payload;
  logic [3:0]                    tx_len;
  logic [3:0]                    tx_left_reg;
  logic [BAUD_W-1:0]             tx_cnt_reg;
  logic                          tx_busy_reg;
  logic                          tx_out_reg;

  // Payload: data LSB first, then parity or ninth bit
  always_comb begin
    tx_payload = '0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nbits) begin
        tx_payload[i] = REG_WDATA_IN[i];
      end
    end
    if (mode_sel == ufw_pkg::MODE_UART9) begin
      tx_payload[8] = mode_reg[ufw_pkg::MODE_TX_NINTH];
    end else if (par_on) begin
      tx_payload[nbits] = parity_of({1'b0, REG_WDATA_IN[7:0]}, nbits,
                                    ctrl_reg[ufw_pkg::CTRL_PAR_EVEN]);
    end
  end

  // Frame: start low, payload, then high stop bits fill the rest
  always_comb begin
    tx_frame = '1;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < ufw_pkg::PAYLOAD_W; i++) begin
      if (4'(i) < nbits + 4'(par_on)) begin
        tx_frame[i + 1] = tx_payload[i];
      end
    end
  end

  // Total bits: start + payload + one or two stops
  assign tx_len = 4'h1 + nbits + 4'(par_on) + (stop_two ? 4'h2 : 4'h1);

  // Writes while a frame is in flight are dropped; there is no second buffer
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= '1;
      tx_left_reg  <= 4'h0;
      tx_cnt_reg   <= '0;
      tx_out_reg   <= 1'b1;
    end else if (!tx_busy_reg) begin
      tx_out_reg <= 1'b1;
      if (wr_data && mode_sel != ufw_pkg::MODE_OFF) begin
        tx_busy_reg  <= 1'b1;
        tx_shift_reg <= tx_frame >> 1;
        tx_out_reg   <= tx_frame[0];
        tx_left_reg  <= tx_len - 4'h1;
        tx_cnt_reg   <= '0;
      end
    end else if (tx_cnt_reg >= baud_reg - BAUD_W'(1)) begin
      tx_cnt_reg <= '0;
      if (tx_left_reg == 4'h0) begin
        tx_busy_reg <= 1'b0;
        tx_out_reg  <= 1'b1;
      end else begin
        tx_out_reg   <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[ufw_pkg::FRAME_W-1:1]};
        tx_left_reg  <= tx_left_reg - 4'h1;
      end
    end else begin
      tx_cnt_reg <= tx_cnt_reg + BAUD_W'(1);
    end
  end

  // Pulse as the last stop bit time ends
  assign tx_done_evt = tx_busy_reg && tx_left_reg == 4'h0 &&
                       tx_cnt_reg >= baud_reg - BAUD_W'(1);

  // Open-drain option drives only the low level so slaves can share a line
  assign SERIAL_OUT_PIN_OUT = mode2_reg[ufw_pkg::MODE2_OPEN_DRN] ? 1'b0 : tx_out_reg;
  assign SERIAL_OUT_OE_OUT  = mode2_reg[ufw_pkg::MODE2_OPEN_DRN] ? ~tx_out_reg : 1'b1;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10,
    RX_STOP  = 2'b11
  } ufw_rx_state_type;

  ufw_rx_state_type              rx_state_reg;
  logic                          rx_meta_reg;
  logic                          rx_sync_reg;
  logic                          rx_prev_reg;
  logic [BAUD_W-1:0]             rx_cnt_reg;
  logic [3:0]                    rx_idx_reg;
  logic [ufw_pkg::PAYLOAD_W-1:0] rx_shift_reg;
  logic [3:0]                    rx_need;
  logic                          rx_tick;
  logic                          rx_ninth;
  logic                          rx_par_bad;
  logic                          rx_stop_ok;

  // Two flops before any logic sees the pin
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= SERIAL_IN_PIN_IN;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  assign rx_need  = nbits + 4'(par_on);
  assign rx_tick  = (rx_state_reg == RX_START) ? (rx_cnt_reg >= (baud_reg >> 1))
                                               : (rx_cnt_reg >= baud_reg - BAUD_W'(1));
  assign rx_ninth = rx_shift_reg[8];
  assign rx_par_bad = par_on &&
                      (rx_shift_reg[nbits] != parity_of(rx_shift_reg[8:0], nbits,
                       ctrl_reg[ufw_pkg::CTRL_PAR_EVEN]));
  assign rx_stop_ok = rx_sync_reg;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_idx_reg   <= 4'h0;
      rx_shift_reg <= '0;
    end else begin
      rx_cnt_reg <= rx_tick ? '0 : rx_cnt_reg + BAUD_W'(1);
      unique case (rx_state_reg)
        RX_IDLE: begin
          rx_cnt_reg <= '0;
          if (mode_reg[ufw_pkg::MODE_RX_ENABLE] && mode_sel != ufw_pkg::MODE_OFF &&
              rx_prev_reg && !rx_sync_reg) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          // Recheck at mid start bit so glitches do not start a frame
          if (rx_tick) begin
            rx_state_reg <= rx_sync_reg ? RX_IDLE : RX_BITS;
            rx_idx_reg   <= 4'h0;
            rx_shift_reg <= '0;
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_shift_reg[rx_idx_reg] <= rx_sync_reg;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg + 4'h1 == rx_need) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // Only the first stop bit is checked, so back to back frames work
          if (rx_tick) begin
            rx_state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  logic rx_end;
  assign rx_end = (rx_state_reg == RX_STOP) && rx_tick;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rx_data_reg   <= 8'h00;
      rx_ninth_reg  <= 1'b0;
      par_err_reg   <= 1'b0;
      frame_err_reg <= 1'b0;
    end else if (rx_end) begin
      rx_data_reg   <= (mode_sel == ufw_pkg::MODE_UART7) ?
                       {1'b0, rx_shift_reg[6:0]} : rx_shift_reg[7:0];
      par_err_reg   <= rx_par_bad;
      frame_err_reg <= !rx_stop_ok;
      if (mode_sel == ufw_pkg::MODE_UART9) begin
        rx_ninth_reg <= rx_ninth;
      end
    end
  end

  // Wake-up filter drops the done and error events of frames with ninth bit 0; data and error flags still load
  logic rx_filtered;
  assign rx_filtered = (mode_sel == ufw_pkg::MODE_UART9) &&
                       mode_reg[ufw_pkg::MODE_WAKEUP] && !rx_ninth;
  assign rx_done_evt = rx_end && !rx_filtered;
  assign rx_err_evt  = rx_end && !rx_filtered && (rx_par_bad || !rx_stop_ok);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        ufw_pkg::OFS_MODE:     rdata_reg <= {27'h0, mode_reg};
        ufw_pkg::OFS_CONTROL:  rdata_reg <= {27'h0, frame_err_reg, par_err_reg,
                                             rx_ninth_reg, ctrl_reg};
        ufw_pkg::OFS_MODE_TWO: rdata_reg <= {30'h0, mode2_reg};
        ufw_pkg::OFS_DATA:     rdata_reg <= {24'h0, rx_data_reg};
        ufw_pkg::OFS_BAUD:     rdata_reg <= 32'(baud_reg);
        ufw_pkg::OFS_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
        ufw_pkg::OFS_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
        ufw_pkg::OFS_STATUS:   rdata_reg <= {30'h0, rx_state_reg != RX_IDLE, tx_busy_reg};
        default:               rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign REG_RDATA_OUT = rdata_reg;

endmodule

// ==== test/ufw_remote.sv ====
// Remote serial controller model facing the UART pins
`timescale 1ns/1ps
module ufw_remote #(
  parameter int BAUD = 8
) (
  // Clock and serial lines
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'h1;
  // Start bit, then the given bits LSB first; the caller supplies the stop bits
  task automatic send(input logic [11:0] b, input int n);
    line_out <= 1'h0;
    repeat (BAUD) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_out <= b[i];
      repeat (BAUD) @(posedge clk);
    end
    line_out <= 1'h1;
  endtask
  // Mid-bit sampling, so a late start edge still lands inside each bit
  task automatic get(input int n, output logic [11:0] b, output logic ok);
    int t;
    b = 12'h000;
    t = 0;
    while (line_in !== 1'h0 && t < 2000) begin
      @(posedge clk);
      t++;
    end
    repeat (BAUD / 2) @(posedge clk);
    ok = (line_in === 1'h0) && (t < 2000);
    for (int i = 0; i < n; i++) begin
      repeat (BAUD) @(posedge clk);
      b[i] = line_in;
    end
  endtask
endmodule

// ==== test/ufw_uart_assertions.sv ====
// Concurrent checks on the UART frame block ports
`timescale 1ns/1ps
module ufw_uart_assertions (
  // Clock and reset
  input wire logic        CLOCK_IN,
  input wire logic        RST_IN,
  // Register port
  input wire logic [4:0]  REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  // Serial pins and interrupt
  input wire logic        SERIAL_IN_PIN_IN,
  input wire logic        SERIAL_OUT_PIN_OUT,
  input wire logic        SERIAL_OUT_OE_OUT,
  input wire logic        IRQ_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  logic [4:0] mode_reg;
  logic [1:0] ctrl_reg;
  logic [1:0] mode2_reg;
  logic [2:0] mask_reg;
  // Released open-drain line reads high through the pull-up
  wire        line = SERIAL_OUT_OE_OUT ? SERIAL_OUT_PIN_OUT : 1'h1;
  // --------------------------------------------------------------
  // Shadow copies of the writable mode, control, mode two and mask fields
  // --------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      mode_reg  <= 5'h00;
      ctrl_reg  <= 2'h0;
      mode2_reg <= 2'h0;
      mask_reg  <= 3'h0;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == ufw_pkg::OFS_MODE) mode_reg <= REG_WDATA_IN[4:0];
      if (REG_ADDR_IN == ufw_pkg::OFS_CONTROL) ctrl_reg <= REG_WDATA_IN[1:0];
      if (REG_ADDR_IN == ufw_pkg::OFS_MODE_TWO) mode2_reg <= REG_WDATA_IN[1:0];
      if (REG_ADDR_IN == ufw_pkg::OFS_IRQ_MASK) mask_reg <= REG_WDATA_IN[2:0];
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_rd_only;
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0;
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside read slot");
  property p_mode_rb;
    $past(REG_RD_IN) && $past(REG_ADDR_IN) == ufw_pkg::OFS_MODE
      |-> REG_RDATA_OUT == {27'h0, $past(mode_reg)};
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  property p_ctrl_rb;
    $past(REG_RD_IN) && $past(REG_ADDR_IN) == ufw_pkg::OFS_CONTROL
      |-> REG_RDATA_OUT[1:0] == $past(ctrl_reg) && REG_RDATA_OUT[31:5] == 27'h0;
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  property p_mode2_rb;
    $past(REG_RD_IN) && $past(REG_ADDR_IN) == ufw_pkg::OFS_MODE_TWO
      |-> REG_RDATA_OUT == {30'h0, $past(mode2_reg)};
  endproperty
  a_mode2_rb: assert property (p_mode2_rb) else $error("mode two readback wrong");
  property p_idle;
    $fell(RST_IN) |-> line && SERIAL_OUT_OE_OUT;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle after reset");
  property p_bit_len;
    $fell(line) |=> !line [*3];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("low bit too short");
  property p_irq_masked;
    mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !IRQ_OUT;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");
  property p_push_pull;
    !mode2_reg[1] && !$past(mode2_reg[1]) |-> SERIAL_OUT_OE_OUT;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull output released");
  property p_open_drain;
    mode2_reg[1] && $past(mode2_reg[1]) |-> !SERIAL_OUT_PIN_OUT;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin drives high");
  c_tx: cover property (REG_WR_IN && REG_ADDR_IN == ufw_pkg::OFS_DATA);
  c_irq: cover property (IRQ_OUT);
  c_rx: cover property ($fell(SERIAL_IN_PIN_IN));
endmodule
bind ufw_uart ufw_uart_assertions u_chk (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .SERIAL_IN_PIN_IN(SERIAL_IN_PIN_IN),
  .SERIAL_OUT_PIN_OUT(SERIAL_OUT_PIN_OUT), .SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT),
  .IRQ_OUT(IRQ_OUT));

// ==== test/testbench.sv ====
// Self-checking bench for the UART frame block
`timescale 1ns/1ps
module testbench;
  localparam int BAUD = 8;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [31:0] rdata;
  logic        pin;
  logic        oe;
  logic        irq;
  logic        rx_line;
  logic        tx_line;
  logic [11:0] got;
  logic        ok;
  logic        ninth = 1'h0;
  logic [2:0]  msk = 3'h0;
  int          n_errors = 0;
  int          n_checks = 0;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
  always #10 clk = ~clk;
  // Pull-up on the shared line, so a released open-drain pin reads high
  assign tx_line = oe ? pin : 1'h1;
  ufw_uart DUT (.CLOCK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .SERIAL_IN_PIN_IN(rx_line),
    .SERIAL_OUT_PIN_OUT(pin), .SERIAL_OUT_OE_OUT(oe), .IRQ_OUT(irq));
  ufw_remote #(.BAUD(BAUD)) rem (.clk(clk), .line_in(tx_line), .line_out(rx_line));
  // --------------------------------------------------------------
  // Register access and frame tasks
  // --------------------------------------------------------------
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    `CHK(nm, e, rdata)
    @(posedge clk);
  endtask
  // Bits after the start bit; f = {st2, b9, ev, par}
  function automatic logic [11:0] frame(input logic [1:0] m, input logic [3:0] f,
      input logic [7:0] d, output int n);
    logic [11:0] e;
    int k;
    e = 12'h000;
    k = (m == 2'h1) ? 7 : 8;
    e[7:0] = (k == 7) ? {1'h0, d[6:0]} : d;
    if (m == 2'h3) begin
      e[k] = f[2];
      k++;
    end else if (f[0]) begin
      e[k] = f[1] ? ^e[7:0] : ~^e[7:0];
      k++;
    end
    e[k] = 1'h1;
    e[k + 1] = f[3];
    n = k + 1 + int'(f[3]);
    return e;
  endfunction
  // f = {od, st2, b9, ev, par}
  task automatic tx_case(input logic [1:0] m, input logic [4:0] f, input logic [7:0] d);
    logic [11:0] e;
    int n;
    e = frame(m, f[3:0], d, n);
    wr_reg(ufw_pkg::OFS_CONTROL, {30'h0, f[1:0]});
    wr_reg(ufw_pkg::OFS_MODE_TWO, {30'h0, f[4:3]});
    wr_reg(ufw_pkg::OFS_MODE, {29'h0, f[2], m});
    wr_reg(ufw_pkg::OFS_DATA, {24'h0, d});
    rem.get(n, got, ok);
    `CHK("tx start", 1'h1, ok)
    `CHK("tx frame", e, got)
    rd_chk("tx busy", ufw_pkg::OFS_STATUS, 32'h1);
    repeat (BAUD) @(posedge clk);
    rd_chk("tx irq", ufw_pkg::OFS_IRQ_STAT, 32'h1);
    wr_reg(ufw_pkg::OFS_IRQ_STAT, 32'h7);
  endtask
  // f = {flip, wu, b9, ev, par}
  task automatic rx_case(input logic [1:0] m, input logic [4:0] f, input logic [7:0] d,
      input logic [2:0] ie);
    logic [11:0] e;
    int n;
    e = frame(m, {1'h0, f[2:0]}, d, n);
    e[(m == 2'h1) ? 7 : 8] ^= f[4];
    wr_reg(ufw_pkg::OFS_CONTROL, {30'h0, f[1:0]});
    wr_reg(ufw_pkg::OFS_MODE, {28'h1, f[3], 1'h0, m});
    rem.send(e, n);
    repeat (4) @(posedge clk);
    if (m == 2'h3) ninth = f[2];
    rd_chk("rx ctrl", ufw_pkg::OFS_CONTROL, {28'h0, f[4], ninth, f[1:0]});
    rd_chk("rx data", ufw_pkg::OFS_DATA, {24'h0, (m == 2'h1) ? {1'h0, d[6:0]} : d});
    rd_chk("rx irq", ufw_pkg::OFS_IRQ_STAT, {29'h0, ie});
    `CHK("irq pin", |(ie & msk), irq)
    wr_reg(ufw_pkg::OFS_IRQ_STAT, 32'h7);
    `CHK("irq clear", 1'h0, irq)
  endtask
  task automatic results();
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd_chk("mode rst", ufw_pkg::OFS_MODE, 32'h0);
    rd_chk("ctrl rst", ufw_pkg::OFS_CONTROL, 32'h0);
    rd_chk("mode2 rst", ufw_pkg::OFS_MODE_TWO, 32'h0);
    rd_chk("baud rst", ufw_pkg::OFS_BAUD, {16'h0, ufw_pkg::BAUD_RESET});
    rd_chk("unmapped", 5'h02, 32'h0);
    // Channel off after reset, so a data write must not start a frame
    wr_reg(ufw_pkg::OFS_DATA, 32'h55);
    rd_chk("tx off", ufw_pkg::OFS_STATUS, 32'h0);
    wr_reg(ufw_pkg::OFS_BAUD, 32'(BAUD));
    tx_case(2'h1, 5'h03, 8'hd3);
    tx_case(2'h1, 5'h09, 8'h5a);
    tx_case(2'h2, 5'h00, 8'ha7);
    tx_case(2'h2, 5'h09, 8'h81);
    tx_case(2'h3, 5'h04, 8'h3c);
    tx_case(2'h3, 5'h18, 8'hf0);
    wr_reg(ufw_pkg::OFS_MODE_TWO, 32'h0);
    wr_reg(ufw_pkg::OFS_IRQ_MASK, 32'h2);
    msk = 3'h2;
    rx_case(2'h1, 5'h03, 8'hb5, 3'h2);
    rx_case(2'h2, 5'h11, 8'h6e, 3'h6);
    rx_case(2'h3, 5'h04, 8'h42, 3'h2);
    rx_case(2'h3, 5'h0c, 8'h01, 3'h2);
    rx_case(2'h3, 5'h08, 8'h99, 3'h0);
    rx_case(2'h3, 5'h00, 8'h99, 3'h2);
    results();
  end
  // Whole run needs under two thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
